// file: di8_regs.svh
// Purpose: offsets, field positions, reset values and timing of the input record link
// Assumes: included by bare name
// Notes: definitions only
`ifndef DI8_REGS_SVH
`define DI8_REGS_SVH

// ----------------------------------------
// clock and filter times
// ----------------------------------------
`define CLK_MHZ 100
`define FLT1_US 100
`define FLT2_US 400
`define FLT3_US 800
`define FLT4_US 1600
`define FLT5_US 3200
`define FLT6_US 10000
`define FLT7_US 20000

// ----------------------------------------
// reset values and fixed descriptors
// ----------------------------------------
`define WB_EN_RST 8'h00
`define FLT_SEL_RST 8'h11
`define MOD_CLASS 8'h1f
`define CH_KIND 8'h70
`define DIAG_BITS 8'h08
`define CH_COUNT 8'h08

// ----------------------------------------
// record numbers, indices and subindices
// ----------------------------------------
`define REC_DIAG_SHORT 16'h0000
`define REC_DIAG_FULL 16'h0001
`define REC_PARAM 16'h0000
`define REC_WB_BYTE 8'h01
`define REC_FLT_BASE 16'h0080
`define CO_DIAG_SHORT 16'h2f00
`define CO_DIAG_FULL 16'h2f01
`define CO_WB 16'h3101
`define CO_FLT_BASE 16'h3102
`define IE_DIAG_OBJ 16'h5005
`define IE_SUB_FIRST 8'h02
`define IE_SUB_LAST 8'h11
`define IE_SUB_TS 8'h13
`define IE_SUB_TS_LAST 8'h16

// ----------------------------------------
// diagnostic record layout
// ----------------------------------------
`define DIAG_LEN 20
`define SHORT_LEN 4
`define REC_CHE_BASE 8
`define REC_TS_BASE 16
`define SUM_FAIL 0
`define SUM_INT 1
`define SUM_EXT 2
`define SUM_CH 3
`define SUM_AUX 4
`define SUM_PARM 7
`define INT_OVF 3
`define INT_COMM 4
`define CHE_PARM 0
`define CHE_WB 4

// ----------------------------------------
// controller registers on the software bus
// ----------------------------------------
`define HOST_ADDR 8'h00
`define HOST_DATA 8'h04
`define HOST_CTRL 8'h08
`define HOST_STAT 8'h0c
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// file: di8_pkg.sv
// Purpose: shared types of the input record link
// Assumes: nothing
// Notes: constants live in di8_regs.svh
package di8_pkg;
  typedef enum logic [1:0] {
    PATH_REC = 2'h0,
    PATH_CO = 2'h1,
    PATH_IE = 2'h2
  } access_path_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } host_state_t;
endpackage

// file: di8_link_if.sv
// Purpose: byte-wide record link between controller and input module
// Assumes: one clock shared by both ends
// Notes: req is held until ack
`timescale 1ns/1ns
interface di8_link_if;
  logic req;
  logic wr;
  di8_pkg::access_path_t path;
  logic [15:0] addr;
  logic [7:0] sub;
  logic [7:0] wdata;
  logic ack;
  logic err;
  logic [7:0] rdata;

  modport dev (
    input req, wr, path, addr, sub, wdata,
    output ack, err, rdata
  );

  modport host (
    output req, wr, path, addr, sub, wdata,
    input ack, err, rdata
  );
endinterface

// file: di8_diag_device.sv
// Purpose: eight-channel input module end: filters, parameters, diagnostic record
// Assumes: inputs synchronous to clock_in; one link request at a time
// Notes: one byte per request; timestamp bytes little endian
//
// Notes on behaviour
// - wire break enable bit per channel
// - filter byte holds even and odd nibble
// - filter codes 1h..7h select 100us..20ms
// - controller passes filter codes unchecked; codes 0h and 8h..Fh are stored and flagged
// - report listed faults; wire break only if enabled
// - record set 01h full, 00h four bytes
// - index 2F01h full, 2F00h four bytes
// - object 5005h, one subindex per byte
// - summary byte flag positions
// - internal byte: overflow bit 3, comm bit 4
// - module class 1111b plus channel-info bit
// - channel kind 70h, digital input
// - diagnostic bits per channel 08h
// - channel count 08h
// - channel error map bit per channel
// - per-channel byte: parameter bit0, break bit4
// - 32-bit microsecond counter from zero, wraps
// - timestamp caught at diagnostic event
`timescale 1ns/1ns
`include "di8_regs.svh"
module di8_diag_device #(
  parameter int TICK_CYCLES = `CLK_MHZ
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // record link
  di8_link_if.dev link,
  // field inputs
  input wire logic [7:0] raw_di_in,
  input wire logic [7:0] wire_break_in,
  // module health
  input wire logic module_fail_in,
  input wire logic aux_supply_missing_in,
  input wire logic buf_overflow_in,
  input wire logic comm_error_in,
  // filtered inputs
  output logic [7:0] filtered_di_out
);

  if (TICK_CYCLES < 1 || TICK_CYCLES > 4096) begin : g_bad_tick
    $error("TICK_CYCLES must be 1 to 4096");
  end

  // ----------------------------------------
  // microsecond tick and counter
  // ----------------------------------------
  logic [11:0] presc;
  logic us_tick;
  logic [31:0] us_count;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      presc <= 12'h000;
      us_tick <= 1'b0;
    end else if (presc == 12'(TICK_CYCLES - 1)) begin
      presc <= 12'h000;
      us_tick <= 1'b1;
    end else begin
      presc <= presc + 12'h001;
      us_tick <= 1'b0;
    end
  end

  // natural wrap of the adder gives the roll-over to zero
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      us_count <= 32'h0000_0000;
    end else if (us_tick) begin
      us_count <= us_count + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  logic wb_hit;
  logic flt_hit;
  logic dg_hit;
  logic [1:0] flt_idx;
  logic [4:0] dg_idx;
  logic [15:0] rel;
  logic take;

  assign take = link.req && !link.ack;

  always_comb begin
    wb_hit = 1'b0;
    flt_hit = 1'b0;
    dg_hit = 1'b0;
    dg_idx = 5'h00;
    rel = 16'h0000;
    case (link.path)
      di8_pkg::PATH_REC: begin
        // record 00h is the parameter set on write, the short record on read
        wb_hit = link.wr && link.addr == `REC_PARAM && link.sub == `REC_WB_BYTE;
        rel = link.addr - `REC_FLT_BASE;
        flt_hit = rel < 16'h0004 && link.sub == 8'h00;
        if (!link.wr && link.addr == `REC_DIAG_FULL && link.sub < 8'(`DIAG_LEN)) begin
          dg_hit = 1'b1;
        end
        if (!link.wr && link.addr == `REC_DIAG_SHORT && link.sub < 8'(`SHORT_LEN)) begin
          dg_hit = 1'b1;
        end
        dg_idx = link.sub[4:0];
      end
      di8_pkg::PATH_CO: begin
        wb_hit = link.addr == `CO_WB && link.sub == 8'h00;
        rel = link.addr - `CO_FLT_BASE;
        flt_hit = rel < 16'h0004 && link.sub == 8'h00;
        if (link.addr == `CO_DIAG_FULL && link.sub < 8'(`DIAG_LEN)) begin
          dg_hit = 1'b1;
        end
        if (link.addr == `CO_DIAG_SHORT && link.sub < 8'(`SHORT_LEN)) begin
          dg_hit = 1'b1;
        end
        dg_idx = link.sub[4:0];
      end
      di8_pkg::PATH_IE: begin
        if (link.addr == `IE_DIAG_OBJ) begin
          if (link.sub >= `IE_SUB_FIRST && link.sub <= `IE_SUB_LAST) begin
            dg_hit = 1'b1;
            dg_idx = 5'(link.sub - `IE_SUB_FIRST);
          end else if (link.sub >= `IE_SUB_TS && link.sub <= `IE_SUB_TS_LAST) begin
            dg_hit = 1'b1;
            dg_idx = 5'(link.sub - `IE_SUB_TS) + 5'(`REC_TS_BASE);
          end
        end
      end
      default: begin
        wb_hit = 1'b0;
      end
    endcase
    flt_idx = rel[1:0];
  end

  // ----------------------------------------
  // parameter registers
  // ----------------------------------------
  logic [7:0] wire_break_enable_mask;
  logic [7:0] filter_time_pair_select [0:3];

  // forbidden codes are stored so that the error stays visible
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      wire_break_enable_mask <= `WB_EN_RST;
      for (int i = 0; i < 4; i++) begin
        filter_time_pair_select[i] <= `FLT_SEL_RST;
      end
    end else if (take && link.wr) begin
      if (wb_hit) begin
        wire_break_enable_mask <= link.wdata;
      end
      if (flt_hit) begin
        filter_time_pair_select[flt_idx] <= link.wdata;
      end
    end
  end

  // ----------------------------------------
  // per-channel filter and error byte
  // ----------------------------------------
  logic [7:0] parm_bad;
  logic [7:0] wb_act;
  logic [7:0] per_channel_error [0:7];

  for (genvar g = 0; g < 8; g++) begin : g_ch
    logic [3:0] code;
    logic [14:0] limit;
    logic [14:0] cnt;

    assign code = filter_time_pair_select[g / 2][4 * (g % 2) +: 4];

    always_comb begin
      case (code)
        4'h1: limit = 15'(`FLT1_US);
        4'h2: limit = 15'(`FLT2_US);
        4'h3: limit = 15'(`FLT3_US);
        4'h4: limit = 15'(`FLT4_US);
        4'h5: limit = 15'(`FLT5_US);
        4'h6: limit = 15'(`FLT6_US);
        4'h7: limit = 15'(`FLT7_US);
        default: limit = 15'(`FLT1_US);
      endcase
    end

    assign parm_bad[g] = code == 4'h0 || code > 4'h7;
    assign wb_act[g] = wire_break_in[g] && wire_break_enable_mask[g];
    assign per_channel_error[g] = (8'(parm_bad[g]) << `CHE_PARM)
                                | (8'(wb_act[g]) << `CHE_WB);

    // a level that flips back before the limit restarts the count
    always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
        cnt <= 15'h0000;
        filtered_di_out[g] <= 1'b0;
      end else if (raw_di_in[g] == filtered_di_out[g]) begin
        cnt <= 15'h0000;
      end else if (us_tick) begin
        if (cnt + 15'h0001 >= limit) begin
          filtered_di_out[g] <= raw_di_in[g];
          cnt <= 15'h0000;
        end else begin
          cnt <= cnt + 15'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // diagnostic flags and timestamp
  // ----------------------------------------
  logic [7:0] channel_error_map;
  logic [7:0] summary_diagnostic_flags;
  logic [7:0] internal_diagnostic_flags;
  logic [23:0] evt_q;
  logic [23:0] evt_now;
  logic [31:0] diag_timestamp;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      channel_error_map[i] = |per_channel_error[i];
    end
    internal_diagnostic_flags = 8'h00;
    internal_diagnostic_flags[`INT_OVF] = buf_overflow_in;
    internal_diagnostic_flags[`INT_COMM] = comm_error_in;
    summary_diagnostic_flags = 8'h00;
    summary_diagnostic_flags[`SUM_FAIL] = module_fail_in;
    summary_diagnostic_flags[`SUM_INT] = |internal_diagnostic_flags;
    summary_diagnostic_flags[`SUM_EXT] = aux_supply_missing_in || |wb_act;
    summary_diagnostic_flags[`SUM_CH] = |channel_error_map;
    summary_diagnostic_flags[`SUM_AUX] = aux_supply_missing_in;
    summary_diagnostic_flags[`SUM_PARM] = |parm_bad;
  end

  assign evt_now = {summary_diagnostic_flags, channel_error_map, internal_diagnostic_flags};

  // only a newly raised flag counts as an event, not one that stays
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      evt_q <= 24'h00_0000;
      diag_timestamp <= 32'h0000_0000;
    end else begin
      evt_q <= evt_now;
      if (|(evt_now & ~evt_q)) begin
        diag_timestamp <= us_count;
      end
    end
  end

  // ----------------------------------------
  // record image and answer
  // ----------------------------------------
  logic [7:0] rec [0:`DIAG_LEN-1];
  logic [7:0] next_rdata;
  logic next_err;

  always_comb begin
    rec[0] = summary_diagnostic_flags;
    rec[1] = `MOD_CLASS;
    rec[2] = 8'h00;
    rec[3] = internal_diagnostic_flags;
    rec[4] = `CH_KIND;
    rec[5] = `DIAG_BITS;
    rec[6] = `CH_COUNT;
    rec[7] = channel_error_map;
    for (int i = 0; i < 8; i++) begin
      rec[`REC_CHE_BASE + i] = per_channel_error[i];
    end
    for (int i = 0; i < 4; i++) begin
      rec[`REC_TS_BASE + i] = diag_timestamp[8 * i +: 8];
    end
  end

  always_comb begin
    next_err = !(wb_hit || flt_hit || dg_hit) || (link.wr && dg_hit);
    if (wb_hit) begin
      next_rdata = wire_break_enable_mask;
    end else if (flt_hit) begin
      next_rdata = filter_time_pair_select[flt_idx];
    end else if (dg_hit) begin
      next_rdata = rec[dg_idx];
    end else begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      link.ack <= 1'b0;
      link.err <= 1'b0;
      link.rdata <= 8'h00;
    end else begin
      link.ack <= take;
      if (take) begin
        link.err <= next_err;
        link.rdata <= next_rdata;
      end
    end
  end

endmodule

// file: di8_diag_host.sv
// Purpose: controller end: software registers on AXI4-Lite, drives the record link
// Assumes: one AXI write and one read at a time
// Notes: starts are ignored while a link request is open
`timescale 1ns/1ns
`include "di8_regs.svh"
module di8_diag_host (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // record link
  di8_link_if.host link,
  // axi write address and data
  input wire logic [7:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  // axi write response
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  // axi read
  input wire logic [7:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in
);

  // ----------------------------------------
  // write channel capture
  // ----------------------------------------
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  assign do_write = !axi_awready_out && !axi_wready_out && !axi_bvalid_out;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      axi_awready_out <= 1'b1;
      aw_addr <= 8'h00;
    end else if (axi_awvalid_in && axi_awready_out) begin
      axi_awready_out <= 1'b0;
      aw_addr <= axi_awaddr_in;
    end else if (do_write) begin
      axi_awready_out <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      axi_wready_out <= 1'b1;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (axi_wvalid_in && axi_wready_out) begin
      axi_wready_out <= 1'b0;
      w_data <= axi_wdata_in;
      w_strb <= axi_wstrb_in;
    end else if (do_write) begin
      axi_wready_out <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      axi_bvalid_out <= 1'b0;
      axi_bresp_out <= `AXI_OKAY;
    end else if (do_write) begin
      axi_bvalid_out <= 1'b1;
      case (aw_addr)
        `HOST_ADDR, `HOST_DATA, `HOST_CTRL, `HOST_STAT: axi_bresp_out <= `AXI_OKAY;
        default: axi_bresp_out <= `AXI_SLVERR;
      endcase
    end else if (axi_bready_in) begin
      axi_bvalid_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // request registers and link sequencer
  // ----------------------------------------
  logic [31:0] req_addr;
  logic [7:0] req_wdata;
  logic busy;
  logic done;
  logic fail;
  logic [7:0] got;
  logic start;
  di8_pkg::host_state_t state;

  assign start = do_write && aw_addr == `HOST_CTRL && w_strb[0] && |w_data[1:0];

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      req_addr <= 32'h0000_0000;
      req_wdata <= 8'h00;
    end else if (do_write && aw_addr == `HOST_ADDR) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb[i]) begin
          req_addr[8 * i +: 8] <= w_data[8 * i +: 8];
        end
      end
    end else if (do_write && aw_addr == `HOST_DATA && w_strb[0]) begin
      req_wdata <= w_data[7:0];
    end
  end

  // write bytes pass unchecked; software must keep filter codes legal
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state <= di8_pkg::ST_IDLE;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      got <= 8'h00;
      link.req <= 1'b0;
      link.wr <= 1'b0;
      link.path <= di8_pkg::PATH_REC;
      link.addr <= 16'h0000;
      link.sub <= 8'h00;
      link.wdata <= 8'h00;
    end else begin
      case (state)
        di8_pkg::ST_IDLE: begin
          if (start) begin
            state <= di8_pkg::ST_WAIT;
            busy <= 1'b1;
            done <= 1'b0;
            link.req <= 1'b1;
            link.wr <= w_data[1];
            link.path <= di8_pkg::access_path_t'(req_addr[25:24]);
            link.addr <= req_addr[15:0];
            link.sub <= req_addr[23:16];
            link.wdata <= req_wdata;
          end
        end
        di8_pkg::ST_WAIT: begin
          if (link.ack) begin
            state <= di8_pkg::ST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            fail <= link.err;
            got <= link.rdata;
            link.req <= 1'b0;
          end
        end
        default: begin
          state <= di8_pkg::ST_IDLE;
          link.req <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      axi_arready_out <= 1'b1;
      axi_rvalid_out <= 1'b0;
      axi_rdata_out <= 32'h0000_0000;
      axi_rresp_out <= `AXI_OKAY;
    end else if (axi_arvalid_in && axi_arready_out) begin
      axi_arready_out <= 1'b0;
      axi_rvalid_out <= 1'b1;
      axi_rresp_out <= `AXI_OKAY;
      case (axi_araddr_in)
        `HOST_ADDR: axi_rdata_out <= req_addr;
        `HOST_DATA: axi_rdata_out <= {24'h00_0000, req_wdata};
        `HOST_CTRL: axi_rdata_out <= 32'h0000_0000;
        `HOST_STAT: axi_rdata_out <= {16'h0000, got, 5'h00, fail, done, busy};
        default: begin
          axi_rdata_out <= 32'h0000_0000;
          axi_rresp_out <= `AXI_SLVERR;
        end
      endcase
    end else if (axi_rvalid_out && axi_rready_in) begin
      axi_rvalid_out <= 1'b0;
      axi_arready_out <= 1'b1;
    end
  end

endmodule

// file: di8_link_checker.sv
// Purpose: link checks between controller end and input module end
// Assumes: one clock, synchronous active-high reset
// Notes: watches the interface signals only
`timescale 1ns/1ns
module di8_link_checker (
  // clock and reset
  input logic clock_in,
  input logic sys_rst_in,
  // record link
  input logic req,
  input logic wr,
  input di8_pkg::access_path_t path,
  input logic [15:0] addr,
  input logic [7:0] sub,
  input logic [7:0] wdata,
  input logic ack,
  input logic err,
  input logic [7:0] rdata
);
  // ----------------------------------------
  // request taken at this edge
  // ----------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  logic rd;
  logic rec;
  assign rd = req && !ack && !wr;
  assign rec = rd && path == di8_pkg::PATH_REC;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_ACK_NEXT: assert property (req && !ack |=> ack)
    else $error("request without answer");
  AST_ACK_PULSE: assert property ($rose(ack) |=> !ack)
    else $error("answer longer than one cycle");
  AST_CLASS: assert property (rec && addr == 16'h0001 && sub == 8'h01 |=> !err && rdata == 8'h1f)
    else $error("module class byte wrong");
  AST_KIND: assert property (rd && path == di8_pkg::PATH_CO
    && addr == 16'h2f01 && sub == 8'h04 |=> rdata == 8'h70)
    else $error("channel kind byte wrong");
  AST_NBITS: assert property (rd && path == di8_pkg::PATH_IE
    && addr == 16'h5005 && sub == 8'h07 |-> ##1 rdata == 8'h08)
    else $error("bits per channel wrong");
  AST_NCH: assert property (rec && addr == 16'h0001 && sub == 8'h06 |=> rdata == 8'h08)
    else $error("channel count wrong");
  AST_SHORT: assert property (rec && addr == 16'h0000 && sub == 8'h04 |=> ack && err)
    else $error("short record not limited to four bytes");
  AST_CO_SHORT: assert property (rd && path == di8_pkg::PATH_CO
    && addr == 16'h2f00 && sub == 8'h04 |=> err)
    else $error("short index not limited");
  AST_SUM_RSVD: assert property (rec && addr == 16'h0001 && sub == 8'h00 |=> rdata[6:5] == 2'b00)
    else $error("summary reserved bits set");
  AST_INT_RSVD: assert property (rec && addr == 16'h0000 && sub == 8'h03
    |=> rdata[2:0] == 3'h0 && rdata[7:5] == 3'h0) else $error("internal reserved bits set");
endmodule

// file: testbench.sv
// Purpose: drives both ends through software registers and field inputs
// Assumes: TICK_CYCLES 2, so one microsecond is two clocks
// Notes: slow filter codes make up most of the run
`timescale 1ns/1ns
`include "di8_regs.svh"
module testbench;
  localparam logic [1:0] rec = di8_pkg::PATH_REC;
  localparam logic [1:0] co = di8_pkg::PATH_CO;
  localparam logic [1:0] ie = di8_pkg::PATH_IE;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] aw_addr = 8'h00;
  logic [7:0] ar_addr = 8'h00;
  logic [31:0] w_data = 32'h0;
  logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
  logic aw_rdy, w_rdy, b_valid, ar_rdy, r_valid;
  logic [1:0] b_resp, r_resp, br, rr;
  logic [31:0] r_data;
  logic [7:0] raw_di = 8'h00;
  logic [7:0] wb_in = 8'h00;
  logic [7:0] filt;
  logic fail = 1'b0, aux = 1'b0, ovf = 1'b0, comm = 1'b0, tag_rd = 1'b0;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  int err_count = 0, cmp_count = 0, cyc = 0, seed = 58903;
  int lim_us[7] = '{`FLT1_US, `FLT2_US, `FLT3_US, `FLT4_US, `FLT5_US, `FLT6_US, `FLT7_US};
  di8_link_if link();
  di8_diag_host u_di8_diag_host (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .link(link),
    .axi_awaddr_in(aw_addr), .axi_awvalid_in(aw_valid), .axi_awready_out(aw_rdy),
    .axi_wdata_in(w_data), .axi_wstrb_in(4'hf), .axi_wvalid_in(w_valid), .axi_wready_out(w_rdy),
    .axi_bresp_out(b_resp), .axi_bvalid_out(b_valid), .axi_bready_in(b_ready),
    .axi_araddr_in(ar_addr), .axi_arvalid_in(ar_valid), .axi_arready_out(ar_rdy),
    .axi_rdata_out(r_data), .axi_rresp_out(r_resp), .axi_rvalid_out(r_valid),
    .axi_rready_in(r_ready));
  di8_diag_device #(.TICK_CYCLES(2)) u_di8_diag_device (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .link(link), .raw_di_in(raw_di), .wire_break_in(wb_in),
    .module_fail_in(fail), .aux_supply_missing_in(aux), .buf_overflow_in(ovf),
    .comm_error_in(comm), .filtered_di_out(filt));
  di8_link_checker u_di8_link_checker (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .req(link.req), .wr(link.wr), .path(link.path), .addr(link.addr), .sub(link.sub),
    .wdata(link.wdata), .ack(link.ack), .err(link.err), .rdata(link.rdata));
  always #5 clock_in = ~clock_in;
  // ----------------------------------------
  // bus tasks and compare
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (aw_rdy) aw_valid <= 1'b0;
      if (w_rdy) w_valid <= 1'b0;
    end while (b_valid !== 1'b1);
    br = b_resp;
    b_ready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_in);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (ar_rdy) ar_valid <= 1'b0;
    end while (r_valid !== 1'b1);
    d = r_data;
    rr = r_resp;
    r_ready <= 1'b0;
  endtask
  // one link transfer; status word noted for the watcher
  task automatic op(input logic [1:0] p, input logic [15:0] a, input logic [7:0] s,
      input logic w, input logic [7:0] wd, input logic [7:0] eb, input logic ee);
    logic [31:0] d;
    axw(`HOST_ADDR, {6'h0, p, s, a});
    axw(`HOST_DATA, {24'h0, wd});
    axw(`HOST_CTRL, {30'h0, w, !w});
    d = 32'h0;
    while (d[1] !== 1'b1) axr(`HOST_STAT, d);
    exp_q.push_back({w ? 32'h0000_00ff : 32'h0000_ffff, 16'h0, eb, 5'h0, ee, 2'b10});
    tag_rd <= 1'b1;
    axr(`HOST_STAT, d);
    tag_rd <= 1'b0;
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock_in) begin
    if (r_valid && r_ready && tag_rd && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check("status word", e[31:0], r_data & e[63:32]);
    end
  end
  // sized for the whole run through all seven filter codes plus margin
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_count++;
      test_done();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int lim;
    logic lvl;
    logic [7:0] h;
    logic [31:0] d;
    lvl = 1'b0;
    repeat (6) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    op(rec, 16'h0001, 8'h01, 0, 8'h00, 8'h1f, 0);
    op(rec, 16'h0001, 8'h02, 0, 8'h00, 8'h00, 0);
    op(rec, 16'h0001, 8'h04, 0, 8'h00, 8'h70, 0);
    op(rec, 16'h0001, 8'h05, 0, 8'h00, 8'h08, 0);
    op(rec, 16'h0001, 8'h06, 0, 8'h00, 8'h08, 0);
    op(rec, 16'h0000, 8'h03, 0, 8'h00, 8'h00, 0);
    op(rec, 16'h0000, 8'h04, 0, 8'h00, 8'h00, 1);
    op(co, 16'h2f00, 8'h04, 0, 8'h00, 8'h00, 1);
    op(co, 16'h2f01, 8'h04, 0, 8'h00, 8'h70, 0);
    op(co, 16'h2f01, 8'h00, 1, 8'h55, 8'h00, 1);
    op(ie, 16'h5005, 8'h07, 0, 8'h00, 8'h08, 0);
    op(ie, 16'h5005, 8'h08, 0, 8'h00, 8'h08, 0);
    op(co, 16'h3101, 8'h00, 0, 8'h00, 8'h00, 0);
    op(co, 16'h3102, 8'h00, 0, 8'h00, 8'h11, 0);
    axw(8'h10, 32'h0);
    check("bresp", {30'h0, `AXI_SLVERR}, {30'h0, br});
    axr(8'h10, d);
    check("rresp", {30'h0, `AXI_SLVERR}, {30'h0, rr});
    $display("descriptor test done");
    for (int i = 0; i < 6; i++) begin
      h = 8'($random(seed));
      {fail, aux, ovf, comm} <= h[3:0];
      raw_di[7:2] <= h[7:2];
      op(rec, 16'h0001, 8'h00, 0, 8'h00, {3'h0, h[2], 1'b0, h[2], h[1] | h[0], h[3]}, 0);
      op(rec, 16'h0001, 8'h03, 0, 8'h00, {3'h0, h[0], h[1], 3'h0}, 0);
    end
    {fail, aux, ovf, comm} <= 4'h0;
    $display("health test done");
    wb_in <= 8'hff;
    op(co, 16'h3101, 8'h00, 1, 8'h05, 8'h00, 0);
    op(co, 16'h2f01, 8'h07, 0, 8'h00, 8'h05, 0);
    op(ie, 16'h5005, 8'h0a, 0, 8'h00, 8'h10, 0);
    op(ie, 16'h5005, 8'h0b, 0, 8'h00, 8'h00, 0);
    op(rec, 16'h0001, 8'h00, 0, 8'h00, 8'h0c, 0);
    op(rec, 16'h0000, 8'h01, 1, 8'h80, 8'h00, 0);
    op(co, 16'h2f01, 8'h07, 0, 8'h00, 8'h80, 0);
    op(ie, 16'h5005, 8'h16, 0, 8'h00, 8'h00, 0);
    wb_in <= 8'h00;
    $display("wire break test done");
    op(rec, 16'h0080, 8'h00, 1, 8'h18, 8'h00, 0);
    op(rec, 16'h0080, 8'h00, 0, 8'h00, 8'h18, 0);
    op(rec, 16'h0001, 8'h00, 0, 8'h00, 8'h88, 0);
    op(rec, 16'h0001, 8'h08, 0, 8'h00, 8'h01, 0);
    repeat (200) @(posedge clock_in);
    @(negedge clock_in);
    check("idle channels", {26'h0, raw_di[7:2]}, {26'h0, filt[7:2]});
    $display("parameter error test done");
    for (int c = 1; c < 8; c++) begin
      op(co, 16'h3102, 8'h00, 1, {4'h1, 4'(c)}, 8'h00, 0);
      lim = 2 * lim_us[c - 1];
      if (c < 4) begin
        raw_di[0] <= !lvl;
        repeat (lim - 20) @(posedge clock_in);
        raw_di[0] <= lvl;
        repeat (lim + 10) @(posedge clock_in);
        @(negedge clock_in);
        check("short pulse", {31'h0, lvl}, {31'h0, filt[0]});
      end
      @(posedge clock_in);
      raw_di[0] <= !lvl;
      repeat (lim - 6) @(posedge clock_in);
      @(negedge clock_in);
      check("before filter time", {31'h0, lvl}, {31'h0, filt[0]});
      repeat (12) @(posedge clock_in);
      @(negedge clock_in);
      check("after filter time", {31'h0, !lvl}, {31'h0, filt[0]});
      lvl = !lvl;
    end
    $display("filter test done");
    test_done();
  end
endmodule
